// ==== lfs_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module lfs_bus_master (
  input  wire logic       clk,
  input  wire logic       sda_line,
  output var  logic       scl,
  output var  logic       sda_m,
  output var  logic       rd_valid,
  output var  logic [7:0] rd_data
);
  // Released lines sit high through the pull-ups
  initial begin
    scl      = 1'b1;
    sda_m    = 1'b1;
    rd_valid = 1'b0;
    rd_data  = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // ----------------------------------------------------------------
  // Bit level: low phase 4 clk, high phase 4 clk, above the 3 clk floor
  // ----------------------------------------------------------------
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    tick(2);
    scl = 1'b1;
    tick(4);
    r = sda_line;
    scl = 1'b0;
    tick(2);
  endtask : bit_io

  task automatic start();
    sda_m = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask : start

  task automatic stop();
    sda_m = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(4);
  endtask : stop

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte

  // Last byte is answered with a release, which ends the read
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    rd_data = d;
    rd_valid = 1'b1;
    tick(1);
    rd_valid = 1'b0;
    bit_io(last, r);
  endtask : rbyte
endmodule : lfs_bus_master

`default_nettype wire

// ==== lfs_cond_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface lfs_cond_if;
  import lfs_pkg::*;
  logic [NCOND-1:0] cond;

  modport src (output cond);
  modport dst (input  cond);
endinterface : lfs_cond_if

`default_nettype wire

// ==== lfs_cond_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module lfs_cond_sync
  import lfs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [NCOND-1:0] raw_cond,
  lfs_cond_if.src               sync_out
);

  // ----------------------------------------------------------------
  // Two flops per comparator; only stage two is ever looked at
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCOND; i++) begin : g_sync
      logic stage1;
      logic stage2;
      always_ff @(posedge clk) begin
        if (reset) begin
          stage1 <= 1'h0;
          stage2 <= 1'h0;
        end else begin
          stage1 <= raw_cond[i];
          stage2 <= stage1;
        end
      end
      assign sync_out.cond[i] = stage2;
    end
  endgenerate

endmodule : lfs_cond_sync

`default_nettype wire

// ==== lfs_oc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module lfs_oc_timer
  import lfs_pkg::*;
#(
  parameter logic [OC_CNT_W-1:0] LIMIT = OC_CNT_W'(OC_CYCLES)
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic arm,
  input  wire logic overcurrent,
  output var  logic expired
);

  // ----------------------------------------------------------------
  // Counts a continuous overcurrent; any gap restarts it
  // ----------------------------------------------------------------
  logic [OC_CNT_W-1:0] count;
  wire                 at_limit = (count >= LIMIT);

  always_ff @(posedge clk) begin
    if (reset || !arm || !overcurrent) begin
      count   <= '0;
      expired <= 1'h0;
    end else begin
      count   <= at_limit ? count : count + OC_CNT_W'(1);
      expired <= at_limit && !expired;
    end
  end

endmodule : lfs_oc_timer

`default_nettype wire

// ==== lfs_pkg.sv ====
`default_nettype none

package lfs_pkg;

  // ----------------------------------------------------------------
  // Status byte layout
  // ----------------------------------------------------------------
  localparam int STAT_W          = 8;
  localparam int OFF_BIT         = 0;
  localparam int OC_BIT          = 2;
  localparam int PNG_BIT         = 4;
  localparam int OT_BIT          = 6;
  localparam int UV_BIT          = 7;
  localparam int CABLE_BIT       = 0;
  localparam int TONE_BIT        = 2;

  // ----------------------------------------------------------------
  // Control byte layout
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_HI     = 7;
  localparam int CTRL_SEL_LO     = 6;
  localparam logic [1:0] CTRL_SEL_MAIN = 2'h0;
  localparam logic [1:0] CTRL_SEL_AUX  = 2'h2;
  localparam int ON_CTRL_BIT     = 5;
  localparam int CABLE_TEST_BIT  = 2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic OFF_RST       = 1'h1;
  localparam logic PNG_RST       = 1'h1;
  localparam logic ON_CTRL_RST   = 1'h0;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h0a;  // Arbitrary bus address

  // ----------------------------------------------------------------
  // Comparator inputs, one bit each
  // ----------------------------------------------------------------
  localparam int NCOND           = 8;
  localparam int C_OC            = 0;
  localparam int C_OT            = 1;
  localparam int C_UV            = 2;
  localparam int C_BELOW_85      = 3;
  localparam int C_WITHIN_90     = 4;
  localparam int C_TONE          = 5;
  localparam int C_ABOVE_21      = 6;
  localparam int C_BELOW_1995    = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int OC_TIME_MS      = 48;
  localparam int OC_CYCLES       = OC_TIME_MS * 1000 * CLK_MHZ;
  localparam int OC_CNT_W        = 23;

  typedef enum logic [2:0] {
    LFS_IDLE    = 3'h0,
    LFS_ADDR    = 3'h1,
    LFS_ADDR_AK = 3'h2,
    LFS_WR_DATA = 3'h3,
    LFS_WR_AK   = 3'h4,
    LFS_RD_DATA = 3'h5,
    LFS_RD_AK   = 3'h6
  } lfs_state_t;

endpackage : lfs_pkg

`default_nettype wire

// ==== lfs_regs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module lfs_regs_properties
  import lfs_pkg::*;
(
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             scl_in,
  input wire logic             sda_oe,
  input wire logic [NCOND-1:0] raw_cond,
  input wire logic             oc_timer_enable,
  input wire logic             output_on_ctrl,
  input wire logic             cable_test_ctrl,
  input wire logic             output_drive,
  input wire logic             fault_request,
  input wire logic             output_off_flag,
  input wire logic             overcurrent_flag,
  input wire logic             output_out_of_range_flag,
  input wire logic             overtemp_flag,
  input wire logic             supply_low_flag,
  input wire logic             cable_open_flag,
  input wire logic             tone_seen_flag
);
  wire logic any_fault;

  assign any_fault = overcurrent_flag | overtemp_flag | supply_low_flag;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Input histories; five cycles cover the two-flop sync and flag stage
  // ----------------------------------------------------------------
  sequence s_tone_hi; raw_cond[C_TONE] [*5]; endsequence
  sequence s_tone_lo; !raw_cond[C_TONE] [*5]; endsequence
  sequence s_oc_live; (raw_cond[C_OC] && !oc_timer_enable) [*5]; endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_reset_values: assert property (
    $past(reset) |-> output_off_flag && output_out_of_range_flag && !output_drive && !sda_oe)
    else $error("reset values wrong");
  a_off_blocks_drive: assert property (
    output_off_flag && $past(output_off_flag) |-> !output_drive)
    else $error("output driven while off flag set");
  a_range_while_off: assert property (
    !output_drive && $past(!output_drive) |-> output_out_of_range_flag)
    else $error("range flag low while output off");
  a_cable_test_off: assert property (
    !cable_test_ctrl && $past(!cable_test_ctrl) |-> !cable_open_flag)
    else $error("cable flag set with test off");
  a_tone_follows: assert property (s_tone_hi |-> tone_seen_flag)
    else $error("tone flag missed");
  a_tone_drops: assert property (s_tone_lo |-> !tone_seen_flag)
    else $error("tone flag stuck");
  a_oc_follows: assert property (s_oc_live |-> overcurrent_flag)
    else $error("live overcurrent flag missed");
  a_fault_request: assert property (any_fault [*2] |-> fault_request)
    else $error("fault request missing");
  a_off_no_request: assert property (
    $rose(output_off_flag) && !any_fault && !$past(any_fault) |-> !fault_request)
    else $error("off flag raised a request");
  a_fault_kills_on: assert property (
    $rose(overtemp_flag || supply_low_flag) ||
      ($rose(overcurrent_flag) && $past(oc_timer_enable)) |->
      ##[0:2] (output_off_flag && !output_on_ctrl))
    else $error("fault left output enabled");
  a_latch_until_read: assert property (
    $fell(overtemp_flag) || $fell(supply_low_flag) |-> scl_in && !sda_oe)
    else $error("latched fault cleared outside read");
endmodule : lfs_regs_properties

bind lnb_fault_status_regs lfs_regs_properties lfs_regs_properties_inst (
  .clk, .reset, .scl_in, .sda_oe, .raw_cond, .oc_timer_enable, .output_on_ctrl,
  .cable_test_ctrl, .output_drive, .fault_request, .output_off_flag, .overcurrent_flag,
  .output_out_of_range_flag, .overtemp_flag, .supply_low_flag, .cable_open_flag,
  .tone_seen_flag
);

`default_nettype wire

// ==== lnb_fault_status_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

module lnb_fault_status_regs
  import lfs_pkg::*;
#(
  parameter logic [6:0]          DEV_ADDR  = DEV_ADDR_DEF,
  parameter logic [OC_CNT_W-1:0] OC_LIMIT  = OC_CNT_W'(OC_CYCLES)
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output var  logic             sda_out,
  output var  logic             sda_oe,
  input  wire logic [NCOND-1:0] raw_cond,
  input  wire logic             oc_timer_enable,
  output var  logic             output_on_ctrl,
  output var  logic             cable_test_ctrl,
  output var  logic             output_drive,
  output var  logic             fault_request,
  output var  logic             output_off_flag,
  output var  logic             overcurrent_flag,
  output var  logic             output_out_of_range_flag,
  output var  logic             overtemp_flag,
  output var  logic             supply_low_flag,
  output var  logic             cable_open_flag,
  output var  logic             tone_seen_flag
);

  // ----------------------------------------------------------------
  // Comparator synchronisers and overcurrent timer
  // ----------------------------------------------------------------
  lfs_cond_if cond_bus ();

  lfs_cond_sync u_sync (
    .clk      (clk),
    .reset    (reset),
    .raw_cond (raw_cond),
    .sync_out (cond_bus.src)
  );

  wire logic [NCOND-1:0] cond = cond_bus.cond;

  wire logic c_oc        = cond[C_OC];
  wire logic c_ot        = cond[C_OT];
  wire logic c_uv        = cond[C_UV];
  wire logic c_below_85  = cond[C_BELOW_85];
  wire logic c_within_90 = cond[C_WITHIN_90];
  wire logic c_tone      = cond[C_TONE];
  wire logic c_above_21  = cond[C_ABOVE_21];
  wire logic c_below_lo  = cond[C_BELOW_1995];

  logic oc_expired;

  lfs_oc_timer #(
    .LIMIT (OC_LIMIT)
  ) u_oc_timer (
    .clk         (clk),
    .reset       (reset),
    .arm         (oc_timer_enable && output_drive),
    .overcurrent (c_oc),
    .expired     (oc_expired)
  );

  // ----------------------------------------------------------------
  // Bus line sampling and framing
  // ----------------------------------------------------------------
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  wire logic scl_rise = scl_in && !scl_q;
  wire logic scl_fall = !scl_in && scl_q;
  wire logic bus_start = scl_in && scl_q && sda_q && !sda_in;
  wire logic bus_stop  = scl_in && scl_q && !sda_q && sda_in;

  // ----------------------------------------------------------------
  // Status bytes
  // ----------------------------------------------------------------
  logic [STAT_W-1:0] status_primary;
  logic [STAT_W-1:0] status_secondary;

  always_comb begin
    status_primary            = '0;
    status_primary[OFF_BIT]   = output_off_flag;
    status_primary[OC_BIT]    = overcurrent_flag;
    status_primary[PNG_BIT]   = output_out_of_range_flag;
    status_primary[OT_BIT]    = overtemp_flag;
    status_primary[UV_BIT]    = supply_low_flag;
    status_secondary           = '0;
    status_secondary[CABLE_BIT] = cable_open_flag;
    status_secondary[TONE_BIT]  = tone_seen_flag;
  end

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  lfs_state_t        state;
  logic [2:0]        bit_cnt;
  logic              got8;
  logic [7:0]        shift;
  logic              is_read;
  logic              sel_second;
  logic              wrote;
  logic              read_tick;
  logic              master_ack;

  wire logic         addr_match = (shift[7:1] == DEV_ADDR);
  wire logic [7:0]   next_tx    = sel_second ? status_secondary : status_primary;
  wire logic [1:0]   ctrl_sel   = shift[CTRL_SEL_HI:CTRL_SEL_LO];
  wire logic         wr_apply   = (state == LFS_WR_DATA) && scl_fall && got8;
  wire logic         end_write  = bus_stop && wrote;

  always_ff @(posedge clk) begin
    if (reset) begin
      state      <= LFS_IDLE;
      bit_cnt    <= 3'h0;
      got8       <= 1'h0;
      shift      <= 8'h00;
      is_read    <= 1'h0;
      sel_second <= 1'h0;
      wrote      <= 1'h0;
      read_tick  <= 1'h0;
      master_ack <= 1'h0;
      sda_oe     <= 1'h0;
      sda_out    <= 1'h0;
    end else begin
      read_tick <= 1'h0;
      sda_out   <= 1'h0;
      if (bus_start) begin
        state      <= LFS_ADDR;
        bit_cnt    <= 3'h0;
        got8       <= 1'h0;
        sel_second <= 1'h0;
        wrote      <= 1'h0;
        sda_oe     <= 1'h0;
      end else if (bus_stop) begin
        state  <= LFS_IDLE;
        wrote  <= 1'h0;
        sda_oe <= 1'h0;
      end else begin
        unique case (state)
          LFS_IDLE: begin
            sda_oe <= 1'h0;
          end
          LFS_ADDR, LFS_WR_DATA: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 3'h1;
              got8    <= (bit_cnt == 3'h7);
            end else if (scl_fall && got8) begin
              got8 <= 1'h0;
              if (state == LFS_WR_DATA) begin
                wrote  <= 1'h1;
                sda_oe <= 1'h1;
                state  <= LFS_WR_AK;
              end else if (addr_match) begin
                is_read <= shift[0];
                sda_oe  <= 1'h1;
                state   <= LFS_ADDR_AK;
              end else begin
                state <= LFS_IDLE;
              end
            end
          end
          LFS_ADDR_AK, LFS_WR_AK: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (state == LFS_ADDR_AK && is_read) begin
                shift  <= next_tx;
                sda_oe <= !next_tx[7];
                state  <= LFS_RD_DATA;
              end else begin
                sda_oe <= 1'h0;
                state  <= LFS_WR_DATA;
              end
            end
          end
          LFS_RD_DATA: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              shift   <= {shift[6:0], 1'h0};
              if (bit_cnt == 3'h7) begin
                sda_oe <= 1'h0;
                state  <= LFS_RD_AK;
              end else begin
                sda_oe <= !shift[6];
              end
            end
          end
          LFS_RD_AK: begin
            if (scl_rise) begin
              // Ninth clock: flags resample and the pointer moves on
              read_tick  <= 1'h1;
              master_ack <= !sda_in;
              sel_second <= !sel_second;
            end else if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (master_ack) begin
                shift  <= next_tx;
                sda_oe <= !next_tx[7];
                state  <= LFS_RD_DATA;
              end else begin
                state <= LFS_IDLE;
              end
            end
          end
          default: begin
            state <= LFS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control bits written by the master
  // ----------------------------------------------------------------
  // A shutdown fault drops the enable, so a fresh write is needed to
  // restart; a fault in the same cycle as a write wins.
  wire logic fault_trip = oc_expired || c_ot || c_uv;

  always_ff @(posedge clk) begin
    if (reset) begin
      output_on_ctrl  <= ON_CTRL_RST;
      cable_test_ctrl <= 1'h0;
    end else begin
      if (fault_trip) begin
        output_on_ctrl <= 1'h0;
      end else if (wr_apply && ctrl_sel == CTRL_SEL_MAIN) begin
        output_on_ctrl <= shift[ON_CTRL_BIT];
      end
      if (wr_apply && ctrl_sel == CTRL_SEL_AUX) begin
        cable_test_ctrl <= shift[CABLE_TEST_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Latched flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      output_off_flag  <= OFF_RST;
      overcurrent_flag <= 1'h0;
      overtemp_flag    <= 1'h0;
      supply_low_flag  <= 1'h0;
      output_drive     <= 1'h0;
      fault_request    <= 1'h0;
    end else begin
      if (!oc_timer_enable) begin
        overcurrent_flag <= c_oc;
      end else if (oc_expired) begin
        overcurrent_flag <= 1'h1;
      end else if (read_tick) begin
        overcurrent_flag <= 1'h0;
      end
      // Set beats the read-time clear, so a live fault stays visible
      if (c_ot) begin
        overtemp_flag <= 1'h1;
      end else if (read_tick) begin
        overtemp_flag <= 1'h0;
      end
      if (c_uv) begin
        supply_low_flag <= 1'h1;
      end else if (read_tick) begin
        supply_low_flag <= 1'h0;
      end
      if (fault_trip || !output_on_ctrl) begin
        output_off_flag <= 1'h1;
      end else if (end_write) begin
        output_off_flag <= 1'h0;
      end
      output_drive  <= output_on_ctrl && !output_off_flag && !fault_trip;
      // The off flag is left out on purpose: it may be intentional
      fault_request <= overcurrent_flag || overtemp_flag || supply_low_flag;
    end
  end

  // ----------------------------------------------------------------
  // Live flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      output_out_of_range_flag <= PNG_RST;
      cable_open_flag          <= 1'h0;
      tone_seen_flag           <= 1'h0;
    end else begin
      if (!output_drive) begin
        output_out_of_range_flag <= 1'h1;
      end else if (c_below_85) begin
        output_out_of_range_flag <= 1'h1;
      end else if (c_within_90) begin
        output_out_of_range_flag <= 1'h0;
      end
      if (!cable_test_ctrl) begin
        cable_open_flag <= 1'h0;
      end else if (c_above_21) begin
        cable_open_flag <= 1'h1;
      end else if (c_below_lo) begin
        cable_open_flag <= 1'h0;
      end
      tone_seen_flag <= c_tone;
    end
  end

endmodule : lnb_fault_status_regs

`default_nettype wire

// ==== lnb_fault_status_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module lnb_fault_status_regs_tb
  import lfs_pkg::*;
;
  localparam int OC_LIM  = 20;
  localparam int MAX_CYC = 20000;

  logic             clk;
  logic             reset;
  wire logic        scl;
  wire logic        sda_m;
  wire logic        sda;
  logic [NCOND-1:0] raw_cond;
  logic             oc_timer_enable;
  wire logic        sda_out, sda_oe, output_on_ctrl, cable_test_ctrl, output_drive;
  wire logic        fault_request, output_off_flag, overcurrent_flag, overtemp_flag;
  wire logic        output_out_of_range_flag, supply_low_flag, cable_open_flag, tone_seen_flag;
  wire logic        rd_valid;
  wire logic [7:0]  rd_data;
  logic [31:0]      seed;
  logic [31:0]      rnd;
  logic [7:0]       exp_q[$];
  int               failures = 0;
  int               compares = 0;
  int               cycles = 0;
  int               fault_sel[2] = '{C_OT, C_UV};
  logic [7:0]       fault_byte[2] = '{8'h51, 8'h91};

  assign sda = sda_m & (sda_oe ? sda_out : 1'b1);

  lnb_fault_status_regs #(.OC_LIMIT(OC_CNT_W'(OC_LIM))) lnb_fault_status_regs_inst (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .raw_cond(raw_cond), .oc_timer_enable(oc_timer_enable), .output_on_ctrl(output_on_ctrl),
    .cable_test_ctrl(cable_test_ctrl), .output_drive(output_drive),
    .fault_request(fault_request), .output_off_flag(output_off_flag),
    .overcurrent_flag(overcurrent_flag), .output_out_of_range_flag(output_out_of_range_flag),
    .overtemp_flag(overtemp_flag), .supply_low_flag(supply_low_flag),
    .cable_open_flag(cable_open_flag), .tone_seen_flag(tone_seen_flag)
  );

  lfs_bus_master lfs_bus_master_inst (
    .clk(clk), .sda_line(sda), .scl(scl), .sda_m(sda_m), .rd_valid(rd_valid), .rd_data(rd_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    if (rd_valid) begin
      check("status byte", rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == MAX_CYC) begin
      failures++;
      $display("CHECK FAILED run length expected end seen hang");
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Bus transfers
  // ----------------------------------------------------------------
  task automatic settle(input int n);
    lfs_bus_master_inst.tick(n);
  endtask : settle

  task automatic wr_ctrl(input logic [7:0] value);
    logic ack;
    lfs_bus_master_inst.start();
    lfs_bus_master_inst.wbyte({DEV_ADDR_DEF, 1'b0}, ack);
    lfs_bus_master_inst.wbyte(value, ack);
    lfs_bus_master_inst.stop();
    settle(5);
  endtask : wr_ctrl

  task automatic rd(input int n);
    logic ack;
    lfs_bus_master_inst.start();
    lfs_bus_master_inst.wbyte({DEV_ADDR_DEF, 1'b1}, ack);
    for (int k = 0; k < n; k++) begin
      lfs_bus_master_inst.rbyte(k == n - 1);
    end
    lfs_bus_master_inst.stop();
  endtask : rd

  initial begin
    seed = 32'hcea8;
    reset = 1'b1;
    raw_cond = '0;
    oc_timer_enable = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    settle(2);
    check("reset flags", {output_off_flag, output_out_of_range_flag, fault_request}, 8'h06);
    exp_q.push_back(8'h11);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h11);
    exp_q.push_back(8'h11);
    rd(3);
    rd(1);
    $display("test reset done");
    raw_cond[C_WITHIN_90] = 1'b1;
    wr_ctrl(8'h20);
    check("enable", {output_off_flag, output_out_of_range_flag}, 8'h00);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    rd(2);
    raw_cond[C_WITHIN_90] = 1'b0;
    raw_cond[C_BELOW_85] = 1'b1;
    settle(5);
    check("range low", output_out_of_range_flag, 1'b1);
    raw_cond[C_BELOW_85] = 1'b0;
    settle(5);
    check("range between", output_out_of_range_flag, 1'b1);
    raw_cond[C_WITHIN_90] = 1'b1;
    settle(5);
    check("range back", output_out_of_range_flag, 1'b0);
    $display("test enable done");
    foreach (fault_sel[i]) begin
      raw_cond[fault_sel[i]] = 1'b1;
      settle(5);
      check("fault", {output_on_ctrl, fault_request, output_off_flag}, 8'h03);
      exp_q.push_back(fault_byte[i]);
      exp_q.push_back(fault_byte[i]);
      rd(1);
      rd(1);
      raw_cond[fault_sel[i]] = 1'b0;
      settle(5);
      exp_q.push_back(fault_byte[i]);
      exp_q.push_back(8'h11);
      rd(1);
      rd(1);
      wr_ctrl(8'h20);
    end
    $display("test latched faults done");
    oc_timer_enable = 1'b1;
    raw_cond[C_OC] = 1'b1;
    settle(OC_LIM + 10);
    check("overcurrent trip", {overcurrent_flag, output_off_flag, output_drive}, 8'h06);
    exp_q.push_back(8'h15);
    exp_q.push_back(8'h11);
    rd(1);
    rd(1);
    raw_cond[C_OC] = 1'b0;
    oc_timer_enable = 1'b0;
    wr_ctrl(8'h20);
    raw_cond[C_OC] = 1'b1;
    settle(6);
    check("overcurrent live", overcurrent_flag, 1'b1);
    raw_cond[C_OC] = 1'b0;
    settle(6);
    check("overcurrent gone", overcurrent_flag, 1'b0);
    wr_ctrl(8'h20);
    $display("test overcurrent done");
    repeat (6) begin
      rnd = $random(seed);
      raw_cond[C_TONE] = rnd[0];
      settle(5);
      check("tone", tone_seen_flag, rnd[0]);
    end
    raw_cond[C_TONE] = 1'b1;
    settle(5);
    for (int k = 0; k < 4; k++) begin
      exp_q.push_back(k[0] ? 8'h04 : 8'h00);
    end
    exp_q.push_back(8'h00);
    rd(4);
    rd(1);
    $display("test tone done");
    wr_ctrl(8'h84);
    check("cable test on", cable_test_ctrl, 1'b1);
    raw_cond[C_ABOVE_21] = 1'b1;
    settle(5);
    check("cable open", cable_open_flag, 1'b1);
    raw_cond[C_ABOVE_21] = 1'b0;
    raw_cond[C_BELOW_1995] = 1'b1;
    settle(5);
    check("cable shut", cable_open_flag, 1'b0);
    raw_cond[C_BELOW_1995] = 1'b0;
    raw_cond[C_ABOVE_21] = 1'b1;
    settle(5);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h05);
    rd(2);
    wr_ctrl(8'h80);
    check("cable test off", cable_open_flag, 1'b0);
    wr_ctrl(8'h00);
    check("switched off", {output_off_flag, fault_request}, 8'h02);
    exp_q.push_back(8'h11);
    rd(1);
    settle(5);
    $display("test cable and switch-off done");
    end_sim();
  end
endmodule : lnb_fault_status_regs_tb

`default_nettype wire
